// [logic/sbst_pkg.sv]
// Behaviour
// - Three-bit instruction shifts in Shift-IR, takes effect at Update-IR.
// - All-zero instruction acts like sample and also floats SRAM outputs.
// - Identification instruction captures fixed 32-bit value and shifts it out.
// - Reset and test-logic-reset load the identification instruction.
// - High-impedance sample selects boundary register and floats SRAM outputs.
// - Sample captures pin ring at Capture-DR; 70 bits x36, 51 bits x18.
// - Shift-DR after capture shifts the boundary register out serially.
// - Update-DR under sample changes nothing, like Pause-DR.
// - Bypass places a single-bit register between data in and out.
// - Identification bit 0 always reads one.
// - Bits 27:23 encode depth, bits 22:18 encode width.
// - Bits 11:1 hold maker code, bits 17:12 a reserved device field.
// - Bits 31:28 hold an unspecified revision number.
// - Codes: 000 ext, 001 id, 010 hiz sample, 100 sample, 111 bypass.
// - Mode select high for five rising test-clock edges resets the port.
// - Capture-IR loads 01 into the two low instruction bits.
// - Sample on rising edges, data out changes on falling; in MSB, out LSB.
package sbst_pkg;
   localparam int IR_W = 3;
   localparam int ID_W = 32;
   localparam int BSR_W36 = 70;
   localparam int BSR_W18 = 51;
   localparam logic [2:0] OP_EXT = 3'h0;
   localparam logic [2:0] OP_ID = 3'h1;
   localparam logic [2:0] OP_HIZ = 3'h2;
   localparam logic [2:0] OP_SAMP = 3'h4;
   localparam logic [2:0] OP_BYP = 3'h7;
   localparam logic [1:0] IR_CAP = 2'h1;
   localparam logic [4:0] DEPTH_512K = 5'h07;
   localparam logic [4:0] DEPTH_1M = 5'h08;
   localparam logic [4:0] WIDTH_X36 = 5'h04;
   localparam logic [4:0] WIDTH_X18 = 5'h03;
   // Arbitrary neutral values
   localparam logic [10:0] MAKER_ID = 11'h055;
   localparam logic [5:0] DEV_ID = 6'h00;
   localparam logic [3:0] REV_ID = 4'h0;
   localparam int TICK_NS = 40;
   localparam int TCK_BENCH_NS = 320;
   typedef enum logic [3:0] {
      ST_RESET = 4'b0000, ST_IDLE = 4'b0001, ST_SELDR = 4'b0010, ST_CAPDR = 4'b0011,
      ST_SHDR = 4'b0100, ST_EX1DR = 4'b0101, ST_PADR = 4'b0110, ST_EX2DR = 4'b0111,
      ST_UPDR = 4'b1000, ST_SELIR = 4'b1001, ST_CAPIR = 4'b1010, ST_SHIR = 4'b1011,
      ST_EX1IR = 4'b1100, ST_PAIR = 4'b1101, ST_EX2IR = 4'b1110, ST_UPIR = 4'b1111
   } sbst_state_t;
endpackage : sbst_pkg

// [logic/sbst_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser with agreement filter
module sbst_pin_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pin and filtered level
   input wire logic pinIn,
   output logic level
);
   logic [2:0] stage_r;
   // Shift chain; stage 0 feeds only stage 1
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage_r <= 3'h0;
      end else begin
         stage_r <= {stage_r[1:0], pinIn};
      end
   end
   // Level moves when stages one and two agree
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         level <= 1'b0;
      end else if (stage_r[1] == stage_r[2]) begin
         level <= stage_r[2];
      end
   end
endmodule : sbst_pin_sync
`default_nettype wire

// [logic/sbst_tap.sv]
`timescale 1ns/1ns
`default_nettype none
// Boundary-scan port of the burst SRAM
module sbst_tap #(
   parameter bit WIDE = 1'b1,
   parameter int BSR_W = sbst_pkg::BSR_W36
) (
   // System
   input wire logic clk,
   input wire logic reset_n,
   // Scan pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdoOe,
   // Pin ring and output control
   input wire logic [BSR_W-1:0] pinRing,
   output logic sramHiz
);
   // Refuse a boundary length that does not suit the width
   if (BSR_W != (WIDE ? sbst_pkg::BSR_W36 : sbst_pkg::BSR_W18)) begin : g_bad_len
      $error("boundary length does not match width");
   end

   logic tckS, tmsS, tdiS, tckD_r;
   sbst_pin_sync uTck (.clk(clk), .reset_n(reset_n), .pinIn(tck), .level(tckS));
   sbst_pin_sync uTms (.clk(clk), .reset_n(reset_n), .pinIn(tms), .level(tmsS));
   sbst_pin_sync uTdi (.clk(clk), .reset_n(reset_n), .pinIn(tdi), .level(tdiS));

   // Test clock edges
   wire rise = tckS & ~tckD_r;
   wire fall = ~tckS & tckD_r;

   sbst_pkg::sbst_state_t st_r, st_nxt;
   logic [2:0] irSh_r, ir_r;
   logic [31:0] idSh_r;
   logic [BSR_W-1:0] bsr_r;
   logic byp_r;
   logic [2:0] tmsRun_r;

   wire [4:0] depthCode = WIDE ? sbst_pkg::DEPTH_512K : sbst_pkg::DEPTH_1M;
   wire [4:0] widthCode = WIDE ? sbst_pkg::WIDTH_X36 : sbst_pkg::WIDTH_X18;
   wire [31:0] idValue = {sbst_pkg::REV_ID, depthCode, widthCode, sbst_pkg::DEV_ID, sbst_pkg::MAKER_ID, 1'b1};

   wire selId = (ir_r == sbst_pkg::OP_ID);
   wire selByp = (ir_r == sbst_pkg::OP_BYP);
   wire selBsr = (ir_r == sbst_pkg::OP_EXT) | (ir_r == sbst_pkg::OP_HIZ) | (ir_r == sbst_pkg::OP_SAMP);
   assign sramHiz = (ir_r == sbst_pkg::OP_EXT) | (ir_r == sbst_pkg::OP_HIZ);

   always_comb begin
      case (st_r)
         sbst_pkg::ST_RESET: st_nxt = tmsS ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
         sbst_pkg::ST_IDLE: st_nxt = tmsS ? sbst_pkg::ST_SELDR : sbst_pkg::ST_IDLE;
         sbst_pkg::ST_SELDR: st_nxt = tmsS ? sbst_pkg::ST_SELIR : sbst_pkg::ST_CAPDR;
         sbst_pkg::ST_CAPDR: st_nxt = tmsS ? sbst_pkg::ST_EX1DR : sbst_pkg::ST_SHDR;
         sbst_pkg::ST_SHDR: st_nxt = tmsS ? sbst_pkg::ST_EX1DR : sbst_pkg::ST_SHDR;
         sbst_pkg::ST_EX1DR: st_nxt = tmsS ? sbst_pkg::ST_UPDR : sbst_pkg::ST_PADR;
         sbst_pkg::ST_PADR: st_nxt = tmsS ? sbst_pkg::ST_EX2DR : sbst_pkg::ST_PADR;
         sbst_pkg::ST_EX2DR: st_nxt = tmsS ? sbst_pkg::ST_UPDR : sbst_pkg::ST_SHDR;
         sbst_pkg::ST_UPDR: st_nxt = tmsS ? sbst_pkg::ST_SELDR : sbst_pkg::ST_IDLE;
         sbst_pkg::ST_SELIR: st_nxt = tmsS ? sbst_pkg::ST_RESET : sbst_pkg::ST_CAPIR;
         sbst_pkg::ST_CAPIR: st_nxt = tmsS ? sbst_pkg::ST_EX1IR : sbst_pkg::ST_SHIR;
         sbst_pkg::ST_SHIR: st_nxt = tmsS ? sbst_pkg::ST_EX1IR : sbst_pkg::ST_SHIR;
         sbst_pkg::ST_EX1IR: st_nxt = tmsS ? sbst_pkg::ST_UPIR : sbst_pkg::ST_PAIR;
         sbst_pkg::ST_PAIR: st_nxt = tmsS ? sbst_pkg::ST_EX2IR : sbst_pkg::ST_PAIR;
         sbst_pkg::ST_EX2IR: st_nxt = tmsS ? sbst_pkg::ST_UPIR : sbst_pkg::ST_SHIR;
         sbst_pkg::ST_UPIR: st_nxt = tmsS ? sbst_pkg::ST_SELDR : sbst_pkg::ST_IDLE;
         default: st_nxt = sbst_pkg::ST_RESET;
      endcase
   end

   // Edge history
   always_ff @(posedge clk) begin
      if (!reset_n) tckD_r <= 1'b0;
      else tckD_r <= tckS;
   end

   // five high edges always reach reset via graph
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= sbst_pkg::ST_RESET;
      end else if (rise) begin
         st_r <= st_nxt;
      end
   end

   // High-edge run counter, saturating at five
   always_ff @(posedge clk) begin
      if (!reset_n) tmsRun_r <= 3'h0;
      else if (rise) tmsRun_r <= !tmsS ? 3'h0 : (tmsRun_r == 3'h5 ? 3'h5 : tmsRun_r + 3'h1);
   end

   // Instruction path
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irSh_r <= sbst_pkg::OP_ID;
         ir_r <= sbst_pkg::OP_ID;
      end else if (st_r == sbst_pkg::ST_RESET) begin
         ir_r <= sbst_pkg::OP_ID;
         irSh_r <= sbst_pkg::OP_ID;
      end else if (rise) begin
         case (st_r)
            sbst_pkg::ST_CAPIR: irSh_r <= {1'b0, sbst_pkg::IR_CAP};
            sbst_pkg::ST_SHIR: irSh_r <= {tdiS, irSh_r[2:1]};
            sbst_pkg::ST_UPIR: ir_r <= irSh_r;
            default: irSh_r <= irSh_r;
         endcase
      end
   end

   // Data registers
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         idSh_r <= 32'h0000_0000;
         bsr_r <= '0;
         byp_r <= 1'b0;
      end else if (rise && st_r == sbst_pkg::ST_CAPDR) begin
         if (selId) idSh_r <= idValue;
         if (selBsr) bsr_r <= pinRing;
         byp_r <= 1'b0;
      end else if (rise && st_r == sbst_pkg::ST_SHDR) begin
         if (selId) idSh_r <= {tdiS, idSh_r[31:1]};
         if (selBsr) bsr_r <= {tdiS, bsr_r[BSR_W-1:1]};
         if (selByp) byp_r <= tdiS;
      end
   end

   // Serial out selection
   wire shiftIr = (st_r == sbst_pkg::ST_SHIR);
   wire shiftDr = (st_r == sbst_pkg::ST_SHDR);
   wire outBit = shiftIr ? irSh_r[0] : selId ? idSh_r[0] : selBsr ? bsr_r[0] : byp_r;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tdo <= 1'b0;
         tdoOe <= 1'b0;
      end else if (fall) begin
         tdo <= outBit;
         tdoOe <= shiftIr | shiftDr;
      end
   end

   property p_tms_reset;
      @(posedge clk) disable iff (!reset_n)
         (tmsRun_r == 3'h5) |-> (st_r == sbst_pkg::ST_RESET);
   endproperty
   a_tms_reset: assert property (p_tms_reset) else $error("no reset after five high edges");

   property p_reset_id;
      @(posedge clk) disable iff (!reset_n)
         (st_r == sbst_pkg::ST_RESET) |=> (ir_r == sbst_pkg::OP_ID);
   endproperty
   a_reset_id: assert property (p_reset_id) else $error("instruction not id in reset");

   property p_ir_update;
      @(posedge clk) disable iff (!reset_n)
         (ir_r != $past(ir_r)) |-> ($past(st_r) == sbst_pkg::ST_UPIR || $past(st_r) == sbst_pkg::ST_RESET);
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("instruction changed outside update");

   property p_cap_ir;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_CAPIR) |=> (irSh_r[1:0] == 2'h1);
   endproperty
   a_cap_ir: assert property (p_cap_ir) else $error("capture pattern wrong");

   property p_id_bit0;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_CAPDR && selId) |=> (idSh_r[0] && idSh_r[27:18] ==
            (WIDE ? {sbst_pkg::DEPTH_512K, sbst_pkg::WIDTH_X36} : {sbst_pkg::DEPTH_1M, sbst_pkg::WIDTH_X18}));
   endproperty
   a_id_bit0: assert property (p_id_bit0) else $error("id capture wrong");

   property p_ext_hiz;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_UPIR &&
            (irSh_r == sbst_pkg::OP_EXT || irSh_r == sbst_pkg::OP_HIZ)) |=> sramHiz;
   endproperty
   a_ext_hiz: assert property (p_ext_hiz) else $error("outputs not floated");

   property p_no_preload;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_UPDR) |=> $stable(bsr_r);
   endproperty
   a_no_preload: assert property (p_no_preload) else $error("update changed boundary");

   property p_bsr_cap;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_CAPDR && selBsr) |=> (bsr_r == $past(pinRing));
   endproperty
   a_bsr_cap: assert property (p_bsr_cap) else $error("boundary capture wrong");

   property p_byp;
      @(posedge clk) disable iff (!reset_n)
         (rise && shiftDr && selByp) |=> (byp_r == $past(tdiS));
   endproperty
   a_byp: assert property (p_byp) else $error("bypass stage wrong");

   // data out moves on falls only
   property p_tdo_fall;
      @(posedge clk) disable iff (!reset_n)
         !fall |=> ($stable(tdo) && $stable(tdoOe));
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved off a fall");

   property p_tdo_oe;
      @(posedge clk) disable iff (!reset_n)
         fall |=> (tdoOe == $past(shiftIr || shiftDr));
   endproperty
   a_tdo_oe: assert property (p_tdo_oe) else $error("out enable wrong");

   property p_tdo_ir;
      @(posedge clk) disable iff (!reset_n)
         (fall && shiftIr) |=> (tdo == $past(irSh_r[0]));
   endproperty
   a_tdo_ir: assert property (p_tdo_ir) else $error("instruction bit not presented");

   property p_ir_shift;
      @(posedge clk) disable iff (!reset_n)
         (rise && shiftIr) |=> (irSh_r == {$past(tdiS), $past(irSh_r[2:1])});
   endproperty
   a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong");

   property p_id_shift;
      @(posedge clk) disable iff (!reset_n)
         (rise && shiftDr && selId) |=> (idSh_r == {$past(tdiS), $past(idSh_r[31:1])});
   endproperty
   a_id_shift: assert property (p_id_shift) else $error("identification shift wrong");

   property p_bsr_shift;
      @(posedge clk) disable iff (!reset_n)
         (rise && shiftDr && selBsr) |=> (bsr_r == {$past(tdiS), $past(bsr_r[BSR_W-1:1])});
   endproperty
   a_bsr_shift: assert property (p_bsr_shift) else $error("boundary shift wrong");

   property p_id_fields;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_CAPDR && selId) |=>
            (idSh_r[31:28] == sbst_pkg::REV_ID && idSh_r[17:1] == {sbst_pkg::DEV_ID, sbst_pkg::MAKER_ID});
   endproperty
   a_id_fields: assert property (p_id_fields) else $error("identity fields wrong");

   property p_samp_drive;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_UPIR && irSh_r != sbst_pkg::OP_EXT && irSh_r != sbst_pkg::OP_HIZ) |=> !sramHiz;
   endproperty
   a_samp_drive: assert property (p_samp_drive) else $error("outputs floated wrongly");

   property p_updr_hold;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_UPDR) |=> ($stable(ir_r) && $stable(sramHiz) && $stable(idSh_r) && $stable(byp_r));
   endproperty
   a_updr_hold: assert property (p_updr_hold) else $error("update changed state");

   property p_byp_cap;
      @(posedge clk) disable iff (!reset_n)
         (rise && st_r == sbst_pkg::ST_CAPDR) |=> !byp_r;
   endproperty
   a_byp_cap: assert property (p_byp_cap) else $error("bypass not cleared");

   property p_st_hold;
      @(posedge clk) disable iff (!reset_n)
         !rise |=> $stable(st_r);
   endproperty
   a_st_hold: assert property (p_st_hold) else $error("state moved off a rise");

   property p_shdr_exit;
      @(posedge clk) disable iff (!reset_n)
         (rise && shiftDr && tmsS) |=> (st_r == sbst_pkg::ST_EX1DR);
   endproperty
   a_shdr_exit: assert property (p_shdr_exit) else $error("shift exit wrong");
endmodule : sbst_tap
`default_nettype wire

// [verif/sbst_scan_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
// Behavioural scan controller on the far side of the pins
module sbst_scan_ctrl (
   // Pacing clock
   input wire logic clk,
   // Scan pins
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdoOe
);
   // Parked pins: clock low, pulled-up lines high
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h1;
   end
   // Change while low, read out before the fall
   task automatic step(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      tck <= 1'h1;
      repeat (4) @(posedge clk);
      // Undriven out pin reads as the inverse
      o = tdoOe ? tdo : ~tdo;
      tck <= 1'h0;
   endtask : step
   // Clock parked low until the port has acted on the last edges
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask : settle
   // Five high mode-select edges, then idle
   task automatic reset5();
      logic o;
      repeat (5) step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
      settle();
   endtask : reset5
   task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
      logic o;
      step(1'h1, 1'h1, o);
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
      step(1'h0, 1'h1, o);
      for (int i = 0; i < 3; i++) begin
         step(i == 2, code[i], o);
         cap[i] = o;
      end
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
      settle();
   endtask : load_ir
   // Idle, Capture-DR, n shifts, Update-DR, idle
   task automatic shift_dr(input int n, input logic [69:0] din, output logic [69:0] dout);
      logic o;
      dout = '0;
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
      step(1'h0, 1'h1, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'h1, 1'h1, o);
      step(1'h0, 1'h1, o);
      settle();
   endtask : shift_dr
endmodule : sbst_scan_ctrl
`default_nettype wire

// [verif/sbst_tap_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module sbst_tap_tb;
   logic clk, reset_n, tck, tms, tdi, tdo, tdoOe, sramHiz, o;
   logic [69:0] pinRing, d;
   logic [2:0] c;
   logic tdo18, tdoOe18, sramHiz18;
   logic [33:0] scan18;
   int numErrors = 0;
   int testsRun = 0;
   int cycles = 0;
   localparam logic [69:0] PAT = 70'h2a_5a5a_c3c3_0f0f_1234;
   localparam logic [31:0] ID_EXP = {sbst_pkg::REV_ID, sbst_pkg::DEPTH_512K, sbst_pkg::WIDTH_X36,
      sbst_pkg::DEV_ID, sbst_pkg::MAKER_ID, 1'h1};
   sbst_tap #(.WIDE(1'h1), .BSR_W(70)) u_sbst_tap (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .pinRing(pinRing), .sramHiz(sramHiz));
   sbst_scan_ctrl u_sbst_scan_ctrl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
   // Narrow part on the same scan pins
   sbst_tap #(.WIDE(1'h0), .BSR_W(sbst_pkg::BSR_W18)) u_sbst_tap_x18 (.clk(clk), .reset_n(reset_n), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo18), .tdoOe(tdoOe18), .pinRing(pinRing[50:0]), .sramHiz(sramHiz18));
   // Narrow part's serial out, taken as the controller reads
   always @(negedge tck) scan18 <= {tdo18, scan18[33:1]};
   // Clock
   always #20 clk = ~clk;
   // Hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         numErrors++;
         finish_test();
      end
   end
   task automatic check(input logic [69:0] seen, input logic [69:0] exp);
      testsRun++;
      if (seen !== exp) begin
         numErrors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("errors %0d of %0d checks", numErrors, testsRun);
      if (numErrors == 0 && testsRun > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   // Identification read straight after reset
   task automatic t_id();
      u_sbst_scan_ctrl.shift_dr(32, '0, d);
      check(d[31:0], ID_EXP);
      check(d[0], 1'h1);
      check(d[27:18], {sbst_pkg::DEPTH_512K, sbst_pkg::WIDTH_X36});
      check(sramHiz, 1'h0);
      check(tdoOe, 1'h0);
      check(scan18[31:0], {sbst_pkg::REV_ID, sbst_pkg::DEPTH_1M, sbst_pkg::WIDTH_X18,
         sbst_pkg::DEV_ID, sbst_pkg::MAKER_ID, 1'h1});
      check(tdoOe18, 1'h0);
   endtask : t_id
   // One-stage path
   task automatic t_bypass();
      u_sbst_scan_ctrl.load_ir(sbst_pkg::OP_BYP, c);
      check(c[1:0], sbst_pkg::IR_CAP);
      u_sbst_scan_ctrl.shift_dr(5, 70'h16, d);
      check(d[4:0], 5'h0c);
   endtask : t_bypass
   // Pin snapshot with and without floating outputs
   task automatic t_sample(input logic [2:0] code, input logic hiz);
      u_sbst_scan_ctrl.load_ir(code, c);
      check(sramHiz, hiz);
      check(sramHiz18, hiz);
      u_sbst_scan_ctrl.shift_dr(70, ~PAT, d);
      check(d, PAT);
      check(scan18[31:0], {~PAT[18:0], PAT[50:38]});
      check(sramHiz, hiz);
   endtask : t_sample
   // New code only at Update-IR
   task automatic t_update();
      u_sbst_scan_ctrl.step(1'h1, 1'h1, o);
      u_sbst_scan_ctrl.step(1'h1, 1'h1, o);
      u_sbst_scan_ctrl.step(1'h0, 1'h1, o);
      u_sbst_scan_ctrl.step(1'h0, 1'h1, o);
      u_sbst_scan_ctrl.settle();
      check(tdoOe, 1'h1);
      for (int i = 0; i < 3; i++) begin
         u_sbst_scan_ctrl.step(i == 2, sbst_pkg::OP_BYP[i], o);
      end
      check(sramHiz, 1'h1);
      u_sbst_scan_ctrl.step(1'h1, 1'h1, o);
      u_sbst_scan_ctrl.step(1'h0, 1'h1, o);
      u_sbst_scan_ctrl.settle();
      check(sramHiz, 1'h0);
   endtask : t_update
   // Five-high reset restores identification
   task automatic t_reset();
      u_sbst_scan_ctrl.load_ir(sbst_pkg::OP_EXT, c);
      u_sbst_scan_ctrl.reset5();
      check(sramHiz, 1'h0);
      u_sbst_scan_ctrl.shift_dr(32, '1, d);
      check(d[31:0], ID_EXP);
   endtask : t_reset
   // Main sequence
   initial begin
      clk = 1'h0;
      reset_n = 1'h0;
      pinRing = '0;
      repeat (10) @(posedge clk);
      reset_n <= 1'h1;
      pinRing <= PAT;
      repeat (5) @(posedge clk);
      u_sbst_scan_ctrl.step(1'h0, 1'h1, o);
      t_id();
      t_bypass();
      t_sample(sbst_pkg::OP_HIZ, 1'h1);
      t_sample(sbst_pkg::OP_SAMP, 1'h0);
      t_sample(sbst_pkg::OP_EXT, 1'h1);
      t_update();
      t_reset();
      finish_test();
   end
endmodule : sbst_tap_tb
`default_nettype wire
